// File: usbeb_pkg.sv
// Constants and shared types of the endpoint buffer command block.
package usbeb_pkg;
    localparam int EP_NUM = 16;
    localparam int FIFO_W = 16;
    localparam int FIFO_D = 4;
    localparam int MEM_AW = 10;
    localparam int MEM_WORDS = 1024;
    localparam logic [4:0] PTR_FIRST = 5'h00;
    localparam logic [4:0] PTR_DATA = 5'h01;
    localparam logic [4:0] PTR_LAST = 5'h10;
    localparam logic [7:0] CMD_BUF_LAST = 8'h1F;
    localparam logic [3:0] GRP_ST_WR = 4'h4;
    localparam logic [3:0] GRP_ST_RD = 4'h5;
    localparam logic [3:0] GRP_VALID = 4'h6;
    localparam logic [3:0] GRP_CLEAR = 4'h7;
    localparam logic [3:0] GRP_CHECK = 4'hD;
    localparam logic [7:0] CMD_VAL_NONE = 8'h60;
    localparam logic [7:0] CMD_CLR_NONE = 8'h71;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hF4;
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [15:0] CTRL_MASK = 16'h0003;
    localparam logic [15:0] EP_NONE = 16'h0000;
    localparam int B_STALL = 7;
    localparam int B_FULL1 = 6;
    localparam int B_FULL0 = 5;
    localparam int B_OVW = 3;
    localparam int B_SETUP = 2;
    localparam int B_CPUSEL = 1;

    typedef enum logic [1:0] {PH_IDLE, PH_STATUS, PH_BUFFER} usbeb_phase_t;

    typedef struct packed {
        logic [2:0] wr_s;
        logic [2:0] rd_s;
        logic [1:0] a0_s;
        logic [1:0][15:0] din_s;
        usbeb_phase_t ph;
        logic [7:0] cmd;
        logic [4:0] ptr;
        logic [15:0] stall;
        logic [15:0] full0;
        logic [15:0] full1;
        logic [15:0] ovw;
        logic [15:0] setup;
        logic [15:0] cpu_sel;
        logic [15:0] usb_sel;
        logic lock;
        logic [15:0] dout;
        logic [15:0] reinit;
        logic dma_on;
        logic [3:0] dma_ep;
        logic dma_buf;
        logic [4:0] dma_ptr;
    } usbeb_state_t;
endpackage

// File: usbeb_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
module usbeb_fifo
    import usbeb_pkg::*;
#(
    parameter int W = FIFO_W,
    parameter int D = FIFO_D
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int CW = $clog2(D) + 1;
    localparam int PW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [CW-1:0] cnt;
        logic [PW-1:0] rd;
    } usbeb_fifo_st_t;

    usbeb_fifo_st_t s;
    usbeb_fifo_st_t n;
    logic push;
    logic pop;

    assign in_ready = s.cnt != CW'(D);
    assign out_valid = s.cnt != '0;
    assign out_data = s.mem[s.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        n = s;
        if (push) begin
            n.mem[PW'(s.rd + s.cnt[PW-1:0])] = in_data;
        end
        if (pop) begin
            n.rd = PW'(s.rd + 1'b1);
        end
        n.cnt = CW'(s.cnt + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule

// File: usbeb_cmd.sv
// Endpoint buffer command interpreter of the parallel-bus USB device.
module usbeb_cmd
    import usbeb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Microcontroller bus pins
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic command_data_select,
    input wire logic [15:0] bus_din,
    output logic [15:0] bus_dout,
    output logic bus_dout_en,
    // Endpoint configuration
    input wire logic [15:0] dbl_buf_en,
    // Serial engine events
    input wire logic [3:0] sie_ep,
    input wire logic sie_setup,
    input wire logic sie_setup_busy,
    input wire logic sie_out_done,
    input wire logic sie_in_done,
    output logic sie_nak,
    output logic [15:0] ep_reinit,
    // DMA read stream
    input wire logic dma_start,
    input wire logic [3:0] dma_ep,
    output logic dma_busy,
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [15:0] dma_data
);
    usbeb_state_t s;
    usbeb_state_t n;
    logic [15:0] mem [0:MEM_WORDS-1];
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [15:0] fl;
    logic wr_ev;
    logic rd_ev;
    logic a0;
    logic [15:0] din;
    logic [7:0] code;
    logic [3:0] cep;
    logic [3:0] ce;
    logic fifo_in_ready;
    logic [15:0] dma_word;
    logic [15:0] cpu_word;

    // Validate and clear are locked on control endpoints until setup is acknowledged.
    function automatic logic ep_open(input logic [3:0] e, input logic lock);
        ep_open = !(lock && (e == EP_CTRL_OUT || e == 4'h1));
    endfunction

    function automatic logic [7:0] status_byte(input usbeb_state_t t, input logic [3:0] e);
        status_byte = 8'h00;
        status_byte[B_STALL] = t.stall[e];
        status_byte[B_FULL1] = t.full1[e];
        status_byte[B_FULL0] = t.full0[e];
        status_byte[B_OVW] = t.ovw[e];
        status_byte[B_SETUP] = t.setup[e];
        status_byte[B_CPUSEL] = t.cpu_sel[e];
    endfunction

    // The strobes are edge detected after the second stage only.
    assign wr_ev = s.wr_s[1] & ~s.wr_s[2];
    assign rd_ev = s.rd_s[1] & ~s.rd_s[2];
    assign a0 = s.a0_s[1];
    assign din = s.din_s[1];
    assign code = din[7:0];
    assign cep = s.cmd[3:0];
    assign ce = code[3:0];
    assign cpu_word = mem[{cep, s.cpu_sel[cep], s.ptr}];
    assign dma_word = mem[{s.dma_ep, s.dma_buf, s.dma_ptr}];

    assign bus_dout = s.dout;
    assign bus_dout_en = s.rd_s[1];
    assign ep_reinit = s.reinit;
    assign dma_busy = s.dma_on;
    assign sie_nak = s.usb_sel[sie_ep] ? s.full1[sie_ep] : s.full0[sie_ep];

    always_comb begin
        n = s;
        fl = EP_NONE;
        mem_we = 1'b0;
        mem_wa = {cep, s.cpu_sel[cep], s.ptr};
        n.wr_s = {s.wr_s[1:0], bus_wr};
        n.rd_s = {s.rd_s[1:0], bus_rd};
        n.a0_s = {s.a0_s[0], command_data_select};
        n.din_s = {s.din_s[0], bus_din};
        n.reinit = EP_NONE;

        if (wr_ev && a0) begin
            n.cmd = code;
            n.ptr = PTR_FIRST;
            n.ph = PH_IDLE;
            if (code <= CMD_BUF_LAST) begin
                n.ph = PH_BUFFER;
            end
            if (code[7:4] == GRP_ST_WR || code[7:4] == GRP_ST_RD || code[7:4] == GRP_CHECK) begin
                n.ph = PH_STATUS;
            end
            if (code[7:4] == GRP_VALID && code != CMD_VAL_NONE && ep_open(ce, s.lock)) begin
                if (s.cpu_sel[ce]) begin
                    n.full1[ce] = 1'b1;
                end else begin
                    n.full0[ce] = 1'b1;
                end
                if (dbl_buf_en[ce]) begin
                    n.cpu_sel[ce] = !s.cpu_sel[ce];
                end
            end
            if (code[7:4] == GRP_CLEAR && code != CMD_CLR_NONE && ep_open(ce, s.lock)) begin
                if (s.cpu_sel[ce]) begin
                    n.full1[ce] = 1'b0;
                end else begin
                    n.full0[ce] = 1'b0;
                end
                n.setup[ce] = 1'b0;
                if (dbl_buf_en[ce]) begin
                    n.cpu_sel[ce] = !s.cpu_sel[ce];
                end
            end
            if (code == CMD_ACK_SETUP) begin
                n.lock = 1'b0;
            end
        end

        if (wr_ev && !a0) begin
            if (s.ph == PH_STATUS && s.cmd[7:4] == GRP_ST_WR) begin
                if (din[B_STALL]) begin
                    n.stall[cep] = 1'b1;
                end else if (s.stall[cep]) begin
                    fl[cep] = 1'b1;
                end
            end
            if (s.ph == PH_BUFFER) begin
                mem_we = 1'b1;
                n.ptr = 5'(s.ptr + 1'b1);
            end
        end

        if (rd_ev && !a0) begin
            if (s.ph == PH_STATUS) begin
                n.dout = {8'h00, status_byte(s, cep)};
                if (s.cmd[7:4] == GRP_ST_RD && !sie_setup_busy) begin
                    n.ovw[cep] = 1'b0;
                end
            end
            if (s.ph == PH_BUFFER) begin
                n.dout = cpu_word;
                n.ptr = 5'(s.ptr + 1'b1);
            end
        end

        if (sie_setup) begin
            fl = fl | (s.stall & CTRL_MASK);
        end

        n.stall = n.stall & ~fl;
        n.full0 = n.full0 & ~fl;
        n.full1 = n.full1 & ~fl;
        n.cpu_sel = n.cpu_sel & ~fl;
        n.usb_sel = n.usb_sel & ~fl;
        n.reinit = fl;

        // Engine events come last so that a hardware set beats a same-cycle clear.
        if (sie_out_done) begin
            if (n.usb_sel[sie_ep]) begin
                n.full1[sie_ep] = 1'b1;
            end else begin
                n.full0[sie_ep] = 1'b1;
            end
            if (dbl_buf_en[sie_ep]) begin
                n.usb_sel[sie_ep] = !n.usb_sel[sie_ep];
            end
        end
        if (sie_in_done) begin
            if (n.usb_sel[sie_ep]) begin
                n.full1[sie_ep] = 1'b0;
            end else begin
                n.full0[sie_ep] = 1'b0;
            end
            if (dbl_buf_en[sie_ep]) begin
                n.usb_sel[sie_ep] = !n.usb_sel[sie_ep];
            end
        end
        if (sie_setup) begin
            if (s.setup[EP_CTRL_OUT] && s.lock) begin
                n.ovw[EP_CTRL_OUT] = 1'b1;
            end
            n.setup[EP_CTRL_OUT] = 1'b1;
            n.full0[EP_CTRL_OUT] = 1'b1;
            n.lock = 1'b1;
        end

        if (dma_start && !s.dma_on) begin
            n.dma_on = 1'b1;
            n.dma_ep = dma_ep;
            n.dma_buf = s.cpu_sel[dma_ep];
            n.dma_ptr = PTR_DATA;
        end
        if (s.dma_on && fifo_in_ready) begin
            n.dma_ptr = 5'(s.dma_ptr + 1'b1);
            if (s.dma_ptr == PTR_LAST) begin
                if (dbl_buf_en[s.dma_ep] && !s.dma_buf) begin
                    n.dma_buf = 1'b1;
                    n.dma_ptr = PTR_DATA;
                end else begin
                    n.dma_on = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Buffer storage has no reset; contents are undefined until written.
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_wa] <= din;
        end
    end

    usbeb_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(s.dma_on),
        .in_ready(fifo_in_ready),
        .in_data(dma_word),
        .out_valid(dma_valid),
        .out_ready(dma_ready),
        .out_data(dma_data)
    );

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_STALL_WRITE: assert property (
        wr_ev && !a0 && s.ph == PH_STATUS && s.cmd[7:4] == GRP_ST_WR && din[B_STALL] && !sie_setup
        |=> s.stall[$past(cep)]) else $error("Stall write did not stall the endpoint.");
    AST_SETUP_UNSTALL: assert property (
        sie_setup && !wr_ev |=> !s.stall[0] && !s.stall[1]) else $error("Setup left control stalled.");
    AST_FLUSH: assert property (
        |s.reinit && !$past(sie_out_done) |-> (s.reinit & (s.full1 | s.stall)) == 16'h0000
        && (s.reinit & s.full0 & ~{15'h0000, $past(sie_setup)}) == 16'h0000)
        else $error("Unstalled endpoint was not flushed.");
    AST_SETUP_FLAG: assert property (
        sie_setup |=> s.setup[0] && s.full0[0] && s.lock) else $error("Setup flag not set.");
    AST_SETUP_OVERWRITTEN: assert property (
        sie_setup && s.setup[0] && s.lock |=> s.ovw[0] ##1 (s.ovw[0] || $past(rd_ev && !a0)))
        else $error("Setup_overwritten flag not held.");
    AST_VALIDATE: assert property (
        wr_ev && a0 && code[7:4] == GRP_VALID && code != CMD_VAL_NONE && ep_open(ce, s.lock)
        && !s.cpu_sel[ce] && !sie_in_done && !sie_setup |=> s.full0[$past(ce)]) else $error("Validate did not fill.");
    AST_TOGGLE: assert property (
        wr_ev && a0 && code[7:4] == GRP_CLEAR && code != CMD_CLR_NONE && ep_open(ce, s.lock)
        && dbl_buf_en[ce] && !sie_setup |=> s.cpu_sel[$past(ce)] != $past(s.cpu_sel[ce]))
        else $error("Clear did not switch buffer.");
    AST_OUT_FULL: assert property (
        sie_out_done && !sie_in_done && !sie_setup && !wr_ev && !s.usb_sel[sie_ep] |=> s.full0[$past(sie_ep)])
        else $error("OUT packet did not set full.");
    AST_CHECK_KEEP: assert property (
        rd_ev && !a0 && s.ph == PH_STATUS && s.cmd[7:4] == GRP_CHECK && !sie_setup
        |=> s.ovw == $past(s.ovw)) else $error("Check command changed status.");
    AST_DMA_SKIP: assert property (
        dma_start && !s.dma_on |=> s.dma_on && s.dma_ptr == PTR_DATA) else $error("DMA did not skip length.");
    AST_DMA_SWITCH: assert property (
        s.dma_on && fifo_in_ready && s.dma_ptr == PTR_LAST && !s.dma_buf && dbl_buf_en[s.dma_ep]
        |=> s.dma_on && s.dma_buf && s.dma_ptr == PTR_DATA) else $error("DMA did not move to secondary.");
endmodule

// File: usbeb_mcu.sv
// Microcontroller model that drives the parallel command and data bus.
module usbeb_mcu (
    // Clock
    input wire logic clk_sys,
    // Bus pins
    output logic bus_wr,
    output logic bus_rd,
    output logic command_data_select,
    output logic [15:0] bus_din,
    input wire logic [15:0] bus_dout,
    input wire logic bus_dout_en
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        command_data_select = 1'b0;
        bus_din = 16'h0000;
    end

    // Each strobe stays high and low four clocks, one more than the minimum.
    task automatic strobe(input logic sel, input logic [15:0] val);
        @(posedge clk_sys);
        command_data_select <= sel;
        bus_din <= val;
        bus_wr <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus_wr <= 1'b0;
        repeat (4) @(posedge clk_sys);
        // The released bus must not keep showing the last value.
        bus_din <= ~val;
    endtask

    task automatic cmd(input logic [15:0] code);
        strobe(1'b1, code);
    endtask

    task automatic wr(input logic [15:0] word);
        strobe(1'b0, word);
    endtask

    // A read only counts while the device really drives the bus.
    task automatic rd(output logic [15:0] d);
        @(posedge clk_sys);
        command_data_select <= 1'b0;
        bus_rd <= 1'b1;
        repeat (4) @(posedge clk_sys);
        d = bus_dout_en ? bus_dout : 16'hXXXX;
        bus_rd <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// File: usbeb_cmd_test.sv
// Self-checking bench of the endpoint buffer command block.
module usbeb_cmd_test
    import usbeb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rst, bus_wr, bus_rd, command_data_select, bus_dout_en;
    logic sie_setup, sie_setup_busy, sie_out_done, sie_in_done, sie_nak;
    logic dma_start, dma_busy, dma_valid, dma_ready, reinit_clr;
    logic [15:0] bus_din, bus_dout, dbl_buf_en, ep_reinit, dma_data, reinit_seen, rd_word;
    logic [3:0] sie_ep, dma_ep;
    int err_total, n_tests;

    usbeb_mcu u_usbeb_mcu (.clk_sys(clk_sys), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .command_data_select(command_data_select), .bus_din(bus_din), .bus_dout(bus_dout),
        .bus_dout_en(bus_dout_en));

    usbeb_cmd u_usbeb_cmd (.clk_sys(clk_sys), .rst(rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .command_data_select(command_data_select), .bus_din(bus_din), .bus_dout(bus_dout),
        .bus_dout_en(bus_dout_en), .dbl_buf_en(dbl_buf_en), .sie_ep(sie_ep), .sie_setup(sie_setup),
        .sie_setup_busy(sie_setup_busy), .sie_out_done(sie_out_done), .sie_in_done(sie_in_done),
        .sie_nak(sie_nak), .ep_reinit(ep_reinit), .dma_start(dma_start), .dma_ep(dma_ep),
        .dma_busy(dma_busy), .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data));

    // Reinit pulses last one cycle, so they are collected here.
    always @(posedge clk_sys) begin
        reinit_seen <= reinit_clr ? 16'h0000 : (reinit_seen | ep_reinit);
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: value mismatch, got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stat(input logic [15:0] code, input logic [15:0] exp);
        u_usbeb_mcu.cmd(code);
        u_usbeb_mcu.rd(rd_word);
        check(rd_word, exp);
    endtask

    task automatic sie_event(input logic [2:0] ev, input logic [3:0] ep);
        @(posedge clk_sys);
        sie_ep <= ep;
        {sie_setup, sie_out_done, sie_in_done} <= ev;
        @(posedge clk_sys);
        {sie_setup, sie_out_done, sie_in_done} <= 3'h0;
    endtask

    task automatic clr_reinit();
        @(posedge clk_sys);
        reinit_clr <= 1'b1;
        @(posedge clk_sys);
        reinit_clr <= 1'b0;
    endtask

    task automatic t_stall();
        stat(16'hAB54, 16'h0000);
        u_usbeb_mcu.cmd(16'h0044);
        u_usbeb_mcu.wr(16'h0080);
        stat(16'h0054, 16'h0080);
        clr_reinit();
        u_usbeb_mcu.cmd(16'h0044);
        u_usbeb_mcu.wr(16'h0066);
        stat(16'h0054, 16'h0000);
        check(reinit_seen, 16'h0010);
    endtask

    task automatic t_out();
        sie_event(3'h2, 4'hE);
        @(negedge clk_sys);
        check({15'h0000, sie_nak}, 16'h0001);
        stat(16'h005E, 16'h0020);
        u_usbeb_mcu.cmd(16'h007E);
        stat(16'h005E, 16'h0000);
        check({15'h0000, sie_nak}, 16'h0000);
    endtask

    task automatic t_valid();
        u_usbeb_mcu.cmd(16'h0061);
        stat(16'h0051, 16'h0020);
        sie_event(3'h1, 4'h1);
        stat(16'h0051, 16'h0000);
    endtask

    task automatic t_setup();
        u_usbeb_mcu.cmd(16'h0040);
        u_usbeb_mcu.wr(16'h0080);
        clr_reinit();
        sie_event(3'h4, 4'h0);
        stat(16'h00D0, 16'h0024);
        check(reinit_seen, 16'h0001);
        sie_event(3'h4, 4'h0);
        stat(16'h00D0, 16'h002C);
        stat(16'h0050, 16'h002C);
        stat(16'h0050, 16'h0024);
        u_usbeb_mcu.cmd(16'h0070);
        stat(16'h0050, 16'h0024);
        u_usbeb_mcu.cmd(16'h00F4);
        u_usbeb_mcu.cmd(16'h0070);
        stat(16'h0050, 16'h0000);
        sie_event(3'h4, 4'h0);
        sie_event(3'h4, 4'h0);
        sie_setup_busy <= 1'b1;
        stat(16'h0050, 16'h002C);
        stat(16'h0050, 16'h002C);
        sie_setup_busy <= 1'b0;
        stat(16'h0050, 16'h002C);
        stat(16'h0050, 16'h0024);
    endtask

    // never more than seventeen words per buffer.
    task automatic fill_buf(input int b);
        u_usbeb_mcu.cmd(16'h000F);
        u_usbeb_mcu.wr(16'h0020);
        for (int i = 1; i <= 16; i++) begin
            u_usbeb_mcu.wr(16'h1000 * 16'(b + 1) + 16'(i));
        end
    endtask

    // DMA runs on into the secondary buffer.
    task automatic t_dma();
        int k;
        k = 0;
        @(posedge clk_sys);
        dbl_buf_en <= 16'hFFF8;
        fill_buf(0);
        u_usbeb_mcu.cmd(16'h006F);
        stat(16'h005F, 16'h0022);
        fill_buf(1);
        u_usbeb_mcu.cmd(16'h006F);
        stat(16'h005F, 16'h0060);
        @(posedge clk_sys);
        dma_ep <= 4'hF;
        dma_start <= 1'b1;
        @(posedge clk_sys);
        dma_start <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check({15'h0000, dma_valid}, 16'h0001);
        dma_ready <= 1'b1;
        for (int n = 0; n < 300 && k < 32; n++) begin
            @(negedge clk_sys);
            if (dma_valid === 1'b1) begin
                check(dma_data, 16'h1000 * 16'(k / 16 + 1) + 16'(k % 16 + 1));
                k++;
            end
        end
        repeat (10) @(posedge clk_sys);
        check(16'(k), 16'h0020);
        check({14'h0000, dma_busy, dma_valid}, 16'h0000);
        u_usbeb_mcu.cmd(16'h007F);
        stat(16'h005F, 16'h0042);
        u_usbeb_mcu.cmd(16'h007F);
        stat(16'h005F, 16'h0000);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        rst = 1'b1;
        dbl_buf_en = 16'h0000;
        sie_ep = 4'h0;
        {sie_setup, sie_out_done, sie_in_done, sie_setup_busy} = 4'h0;
        {dma_start, dma_ready, reinit_clr} = 3'h0;
        dma_ep = 4'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_stall();
        t_out();
        t_valid();
        t_setup();
        t_dma();
        finish_test();
    end
endmodule
